//--- dpc_ctrl_model.sv
// Behavioural memory controller driving the device pins
`timescale 1ns/1ps
`default_nettype none
module dpc_ctrl_model (
   input  wire logic        clk_i,
   output var  logic        ck_o,
   output wire logic        ck_n_o,
   output var  logic        cke_o,
   output var  logic [3:0]  code_o,
   output var  logic [1:0]  bank_o,
   output var  logic [11:0] addr_o,
   output var  logic [3:0]  mask_o,
   output var  logic [3:0]  wstrobe_o,
   output var  logic [31:0] dq_o
);
   import dpc_pkg::*;
   logic       run = 1'b1;
   logic [2:0] ph  = 3'h0;
   initial
      {ck_o, cke_o, code_o, bank_o, addr_o, mask_o, wstrobe_o, dq_o} = {2'h1, 4'hF, 54'h0};
   // Memory clock runs steadily, stopped only in self refresh
   always @(negedge clk_i)
   begin
      if (run)
         ph <= ph + 3'h1;
      if (run && ph == 3'h3)
         ck_o <= 1'b1;
      else if (run && ph == 3'h7)
         ck_o <= 1'b0;
   end
   assign ck_n_o = ~ck_o;
   task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic [11:0] addr, input logic cke);
      @(negedge clk_i iff ph == 3'h7);
      code_o <= code;
      bank_o <= bank;
      addr_o <= addr;
      cke_o  <= cke;
      @(negedge clk_i iff ph == 3'h5);
      code_o <= 4'hF;
      bank_o <= ~bank;
      addr_o <= ~addr;
      @(negedge clk_i iff ph == 3'h3);
   endtask
   // Data settles three cycles before and after each strobe edge
   task automatic write_burst(input logic [31:0] base, input logic [15:0] masks);
      for (int n = 0; n < 4; n++)
      begin
         dq_o   <= base + 32'(n);
         mask_o <= masks[4*n +: 4];
         repeat (3) @(negedge clk_i);
         wstrobe_o <= ~wstrobe_o;
         repeat (3) @(negedge clk_i);
      end
      dq_o <= ~dq_o;
   endtask
   task automatic sr_exit();
      @(negedge clk_i iff ph == 3'h7);
      run <= 1'b0;
      repeat (4) @(negedge clk_i);
      cke_o <= 1'b1;
      run <= 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
   task automatic restart();
      run <= 1'b1;
   endtask
endmodule // dpc_ctrl_model
`default_nettype wire

//--- dpc_dram_pins.sv
// Device-side pin command, address, clock-enable, mask and strobe logic of a four-bank DRAM
//
// Summary of operation
// - Commands and addresses are taken at the rising true-clock crossing.
// - Read data is launched on both rising and falling clock crossings.
// - Clock enable high runs clocks, inputs and drivers; low disables them.
// - Enable low: idle banks give precharge power-down or self refresh, open rows active.
// - Enable sampled on rising crossings except self-refresh exit, which needs no clock.
// - Power-down ignores all but clock and enable; self refresh ignores all but enable.
// - Chip select high masks the command; it is part of the command code.
// - Command decoded from row strobe, column strobe, write command and chip select.
// - Write mask sampled on both edges; masked data stays unwritten.
// - Bank select picks the bank of activate, read, write and single precharge.
// - Activate takes the twelve-bit row from the address bus.
// - Column is address bits zero to seven plus nine; bit eight requests auto-precharge.
// - Precharge with bit eight low hits the selected bank, high hits all banks.
// - Mode register set takes its operation code from the address bus.
// - A read strobe per lane accompanies read data, edge-aligned with it.
// - The 32 data lines are shared: controller writes, device reads.
`timescale 1ns/1ps
`default_nettype none
module dpc_dram_pins (
   input  wire logic                           clk_i,
   input  wire logic                           reset_i,
   // Memory pins
   input  wire logic                           diff_clock_in_i,
   input  wire logic                           diff_clock_in_n_i,
   input  wire logic                           clk_enable_i,
   input  wire logic                           chip_sel_n_i,
   input  wire logic                           row_strobe_n_i,
   input  wire logic                           col_strobe_n_i,
   input  wire logic                           write_cmd_n_i,
   input  wire logic [dpc_pkg::BANK_W-1:0]     bank_select_i,
   input  wire logic [dpc_pkg::ADDR_W-1:0]     addr_bus_i,
   input  wire logic [dpc_pkg::LANES-1:0]      write_byte_mask_i,
   input  wire logic [dpc_pkg::LANES-1:0]      write_strobe_in_i,
   input  wire logic [dpc_pkg::DATA_W-1:0]     data_lines_i,
   output logic      [dpc_pkg::DATA_W-1:0]     data_lines_o,
   output logic                                data_lines_oe_o,
   output logic      [dpc_pkg::LANES-1:0]      read_strobe_out_o,
   output logic                                read_strobe_oe_o,
   // Array side: read data supply
   input  wire logic [dpc_pkg::DATA_W-1:0]     rd_data_i,
   input  wire logic                           rd_valid_i,
   output logic                                rd_ready_o,
   // Array side: requests and write beats
   output logic                                act_o,
   output logic                                rd_req_o,
   output logic                                wr_valid_o,
   output logic      [dpc_pkg::DATA_W-1:0]     wr_data_o,
   output logic      [dpc_pkg::LANES-1:0]      wr_byte_en_o,
   output logic      [dpc_pkg::BANK_W-1:0]     acc_bank_o,
   output logic      [dpc_pkg::ADDR_W-1:0]     acc_row_o,
   output logic      [dpc_pkg::COL_W-1:0]      acc_col_o,
   output logic                                auto_precharge_o,
   output logic                                precharge_o,
   output logic      [dpc_pkg::BANKS-1:0]      precharge_banks_o,
   output logic                                refresh_o,
   output logic      [dpc_pkg::BANKS-1:0]      bank_open_o,
   output logic      [dpc_pkg::ADDR_W-1:0]     mode_reg_o,
   output logic      [dpc_pkg::ADDR_W-1:0]     ext_mode_reg_o,
   output logic      [1:0]                     power_state_o,
   output logic                                read_underrun_o
);
   import dpc_pkg::*;

   // Synchronised pin levels
   logic [SYNC_W-1:0]  pins_raw;
   logic [SYNC_W-1:0]  pins_q;
   logic               ck_t;
   logic               ck_c;
   logic               cke_q;
   logic [3:0]         cmd_q;
   logic [BANK_W-1:0]  ba_q;
   logic [ADDR_W-1:0]  addr_q;
   logic [LANES-1:0]   mask_q;
   logic [LANES-1:0]   wstb_q;
   logic [DATA_W-1:0]  dq_q;

   // Crossing detection and state
   dpc_pwr_t           pwr_reg;
   dpc_pwr_t           pwr_next;
   logic               ck_high;
   logic               ck_high_reg;
   logic               rise;
   logic               fall;
   logic               xing;
   logic               cmd_taken;
   logic               is_act;
   logic               is_rd;
   logic               is_wr;
   logic               is_pre;
   logic               is_ref;
   logic               is_mode;
   logic               sref_entry;
   logic               all_idle;
   logic [BANKS-1:0]   bank_dec;
   logic [BANKS-1:0]   pre_mask;

   // Read path
   logic [2:0]         rd_lat_reg;
   logic [2:0]         rd_beats_reg;
   logic               rd_beat;
   logic               rd_oe_reg;
   logic               rd_stb_reg;
   logic [DATA_W-1:0]  fifo_data;
   logic               fifo_valid;

   // Write path
   logic [2:0]         wr_beats_reg;
   logic [2:0]         wr_idx_reg;
   logic [COL_W-1:0]   wr_col_reg;
   logic               wstb_prev_reg;
   logic               wr_beat;

   assign pins_raw = {diff_clock_in_i, diff_clock_in_n_i, clk_enable_i,
                      chip_sel_n_i, row_strobe_n_i, col_strobe_n_i, write_cmd_n_i,
                      bank_select_i, addr_bus_i, write_byte_mask_i, write_strobe_in_i, data_lines_i};

   dpc_pin_sync #(
      .W (SYNC_W)
   ) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .pin_i   (pins_raw),
      .level_o (pins_q)
   );

   assign ck_t   = pins_q[60];
   assign ck_c   = pins_q[59];
   assign cke_q  = pins_q[58];
   assign cmd_q  = pins_q[57:54];
   assign ba_q   = pins_q[53:52];
   assign addr_q = pins_q[51:40];
   assign mask_q = pins_q[39:36];
   assign wstb_q = pins_q[35:32];
   assign dq_q   = pins_q[31:0];

   // Crossings; the clock pair is ignored in self refresh
   assign ck_high = ck_t & ~ck_c;
   assign rise    = ck_high & ~ck_high_reg & (pwr_reg != PWR_SELF_REF);
   assign fall    = ~ck_high & ck_high_reg & (pwr_reg != PWR_SELF_REF);
   assign xing    = rise | fall;

   // Command decode: chip select high matches no code
   assign cmd_taken  = rise & cke_q & (pwr_reg == PWR_ON);
   assign is_act     = cmd_taken & (cmd_q == CMD_ACT);
   assign is_rd      = cmd_taken & (cmd_q == CMD_READ);
   assign is_wr      = cmd_taken & (cmd_q == CMD_WRITE);
   assign is_pre     = cmd_taken & (cmd_q == CMD_PRE);
   assign is_ref     = cmd_taken & (cmd_q == CMD_REF);
   assign is_mode    = cmd_taken & (cmd_q == CMD_MODE);
   assign sref_entry = rise & ~cke_q & (pwr_reg == PWR_ON) & (cmd_q == CMD_REF);
   assign all_idle   = ~|bank_open_o;

   assign bank_dec = 4'h1 << ba_q;
   assign pre_mask = addr_q[AP_BIT] ? 4'hF : bank_dec;

   // Power state from the clock enable
   always_comb
   begin
      pwr_next = pwr_reg;
      case (pwr_reg)
         PWR_ON:
         begin
            if (rise && !cke_q)
            begin
               if (sref_entry && all_idle)
               begin
                  pwr_next = PWR_SELF_REF;
               end
               else if (all_idle)
               begin
                  pwr_next = PWR_PRE_PD;
               end
               else
               begin
                  pwr_next = PWR_ACT_PD;
               end
            end
         end
         PWR_PRE_PD, PWR_ACT_PD:
         begin
            if (rise && cke_q)
            begin
               pwr_next = PWR_ON;
            end
         end
         PWR_SELF_REF:
         begin
            if (cke_q)
            begin
               pwr_next = PWR_ON;
            end
         end
         default:
         begin
            pwr_next = PWR_ON;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         pwr_reg     <= PWR_ON;
         ck_high_reg <= 1'b0;
      end
      else
      begin
         pwr_reg     <= pwr_next;
         ck_high_reg <= ck_high;
      end
   end

   assign power_state_o = pwr_reg;

   // Bank rows, mode registers and command pulses
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         bank_open_o       <= '0;
         act_o             <= 1'b0;
         rd_req_o          <= 1'b0;
         precharge_o       <= 1'b0;
         precharge_banks_o <= '0;
         refresh_o         <= 1'b0;
         mode_reg_o        <= MODE_RESET;
         ext_mode_reg_o    <= MODE_RESET;
      end
      else
      begin
         act_o       <= is_act;
         rd_req_o    <= is_rd;
         precharge_o <= is_pre;
         refresh_o   <= is_ref;
         if (is_act)
         begin
            bank_open_o <= bank_open_o | bank_dec;
         end
         else if (is_pre)
         begin
            bank_open_o       <= bank_open_o & ~pre_mask;
            precharge_banks_o <= pre_mask;
         end
         if (is_mode && ba_q == EXT_MODE_BANK)
         begin
            ext_mode_reg_o <= addr_q;
         end
         else if (is_mode)
         begin
            mode_reg_o <= addr_q;
         end
      end
   end

   // Access address: row on activate, column on read or write, advanced per write beat
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         acc_bank_o       <= '0;
         acc_row_o        <= '0;
         acc_col_o        <= '0;
         auto_precharge_o <= 1'b0;
      end
      else if (is_act)
      begin
         acc_bank_o <= ba_q;
         acc_row_o  <= addr_q;
      end
      else if (is_rd || is_wr)
      begin
         acc_bank_o       <= ba_q;
         acc_col_o        <= dpc_col_f(addr_q);
         auto_precharge_o <= addr_q[AP_BIT];
      end
      else if (wr_beat)
      begin
         acc_col_o <= dpc_beat_col_f(wr_col_reg, wr_idx_reg);
      end
   end

   // Read data supply; rd_ready_o stalls the array side when full
   dpc_fifo #(
      .W (DATA_W),
      .D (FIFO_DEPTH)
   ) u_rd_fifo (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_data_i   (rd_data_i),
      .in_valid_i  (rd_valid_i),
      .in_ready_o  (rd_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (rd_beat)
   );

   assign rd_beat = xing & (rd_lat_reg == 3'h0) & (rd_beats_reg != 3'h0);

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         rd_lat_reg      <= '0;
         rd_beats_reg    <= '0;
         rd_oe_reg       <= 1'b0;
         rd_stb_reg      <= 1'b0;
         data_lines_o    <= DATA_RESET;
         read_underrun_o <= 1'b0;
      end
      else
      begin
         read_underrun_o <= rd_beat & ~fifo_valid;
         if (is_rd)
         begin
            rd_lat_reg   <= RD_LAT_XING;
            rd_beats_reg <= BURST_BEATS;
         end
         else if (is_wr)
         begin
            rd_beats_reg <= '0;
         end
         else if (xing && rd_lat_reg != 3'h0)
         begin
            rd_lat_reg <= rd_lat_reg - 3'h1;
         end
         else if (rd_beat)
         begin
            rd_beats_reg <= rd_beats_reg - 3'h1;
            data_lines_o <= fifo_valid ? fifo_data : DATA_RESET;
            rd_stb_reg   <= ~rd_stb_reg;
            rd_oe_reg    <= 1'b1;
         end
         else if (xing)
         begin
            rd_oe_reg  <= 1'b0;
            rd_stb_reg <= 1'b0;
         end
      end
   end

   // Drivers are off unless the clock enable has the device awake
   assign data_lines_oe_o   = rd_oe_reg & (pwr_reg == PWR_ON);
   assign read_strobe_oe_o  = rd_oe_reg & (pwr_reg == PWR_ON);
   assign read_strobe_out_o = {LANES{rd_stb_reg}};

   // Write beats are taken on each transition of the lane-zero write strobe
   assign wr_beat = (wstb_q[0] != wstb_prev_reg) & (wr_beats_reg != 3'h0) & (pwr_reg == PWR_ON);

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_beats_reg  <= '0;
         wr_idx_reg    <= '0;
         wr_col_reg    <= '0;
         wstb_prev_reg <= 1'b0;
         wr_valid_o    <= 1'b0;
         wr_data_o     <= DATA_RESET;
         wr_byte_en_o  <= '0;
      end
      else
      begin
         wstb_prev_reg <= wstb_q[0];
         wr_valid_o    <= wr_beat;
         if (is_wr)
         begin
            wr_beats_reg <= BURST_BEATS;
            wr_idx_reg   <= '0;
            wr_col_reg   <= dpc_col_f(addr_q);
         end
         else if (is_rd)
         begin
            wr_beats_reg <= '0;
         end
         else if (wr_beat)
         begin
            wr_beats_reg <= wr_beats_reg - 3'h1;
            wr_idx_reg   <= wr_idx_reg + 3'h1;
            wr_data_o    <= dq_q;
            wr_byte_en_o <= ~mask_q;
         end
      end
   end
endmodule // dpc_dram_pins
`default_nettype wire

//--- dpc_dram_pins_asserts.sv
// Port checker for the DRAM pin command interface
`timescale 1ns/1ps
`default_nettype none
module dpc_dram_pins_chk (
   input wire logic                       clk_i,
   input wire logic                       reset_i,
   input wire logic [dpc_pkg::DATA_W-1:0] data_lines_o,
   input wire logic                       data_lines_oe_o,
   input wire logic [dpc_pkg::LANES-1:0]  read_strobe_out_o,
   input wire logic                       read_strobe_oe_o,
   input wire logic                       act_o,
   input wire logic                       rd_req_o,
   input wire logic                       wr_valid_o,
   input wire logic                       precharge_o,
   input wire logic                       refresh_o,
   input wire logic [dpc_pkg::BANK_W-1:0] acc_bank_o,
   input wire logic [dpc_pkg::BANKS-1:0]  precharge_banks_o,
   input wire logic [dpc_pkg::BANKS-1:0]  bank_open_o,
   input wire logic [1:0]                 power_state_o
);
   import dpc_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_oe_off_down: assert property (power_state_o != PWR_ON |-> !data_lines_oe_o)
      else $error("data bus driven while powered down");
   a_no_cmd_down: assert property (power_state_o != PWR_ON |-> !(act_o || rd_req_o || wr_valid_o))
      else $error("command accepted while powered down");
   a_one_command: assert property ($onehot0({act_o, rd_req_o, precharge_o, refresh_o}))
      else $error("two commands decoded at once");
   a_act_opens: assert property (act_o |-> ##[0:1] bank_open_o[acc_bank_o])
      else $error("activate did not open the addressed bank");
   a_pre_scope: assert property (precharge_o |-> precharge_banks_o == 4'hF || $onehot(precharge_banks_o))
      else $error("precharge hit neither one bank nor all");
   a_pre_closes: assert property (precharge_o |-> ##[0:2] (bank_open_o & precharge_banks_o) == 4'h0)
      else $error("precharged bank still open");
   a_idle_power: assert property (power_state_o inside {PWR_PRE_PD, PWR_SELF_REF} |-> bank_open_o == 4'h0)
      else $error("idle power state with a row open");
   a_strobe_lanes: assert property (read_strobe_out_o == 4'h0 || read_strobe_out_o == 4'hF)
      else $error("read strobe lanes disagree");
   a_strobe_edge: assert property (data_lines_oe_o && $past(data_lines_oe_o) && $changed(data_lines_o)
                                   |-> $changed(read_strobe_out_o) && read_strobe_oe_o)
      else $error("read data moved without its strobe");
   a_burst_hold: assert property ($rose(data_lines_oe_o) |-> data_lines_oe_o [*8])
      else $error("read burst cut short");
   cover property (act_o);
   cover property (refresh_o);
   cover property ($rose(data_lines_oe_o));
   cover property (power_state_o == PWR_SELF_REF);
endmodule // dpc_dram_pins_chk
bind dpc_dram_pins dpc_dram_pins_chk u_dpc_dram_pins_chk (.clk_i, .reset_i, .data_lines_o, .data_lines_oe_o,
   .read_strobe_out_o, .read_strobe_oe_o, .act_o, .rd_req_o, .wr_valid_o, .precharge_o, .refresh_o, .acc_bank_o,
   .precharge_banks_o, .bank_open_o, .power_state_o);
`default_nettype wire

//--- dpc_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dpc_fifo #(
   parameter int W = 32,
   parameter int D = 16
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_reg [D];
   logic [AW:0]  wr_ptr_reg;
   logic [AW:0]  rd_ptr_reg;
   logic         push;
   logic         pop;

   assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
   assign in_ready_o  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule // dpc_fifo
`default_nettype wire

//--- dpc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] pin_i,
   output var  logic [W-1:0] level_o
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] level_next;

   // A bit changes only where the second and third stages agree
   assign level_next = (s2_reg & s3_reg) | (level_o & (s2_reg | s3_reg));

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         s1_reg  <= '0;
         s2_reg  <= '0;
         s3_reg  <= '0;
         level_o <= '0;
      end
      else
      begin
         s1_reg  <= pin_i;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         level_o <= level_next;
      end
   end
endmodule // dpc_pin_sync
`default_nettype wire

//--- dpc_pkg.sv
// Constants, command codes and power states for the DRAM pin command interface
package dpc_pkg;

   localparam int DATA_W     = 32;
   localparam int LANES      = 4;
   localparam int LANE_W     = 8;
   localparam int ADDR_W     = 12;
   localparam int BANK_W     = 2;
   localparam int BANKS      = 4;
   localparam int COL_W      = 9;
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_W     = 61;

   // Address bit positions
   localparam int AP_BIT     = 8;
   localparam int COL_HI_BIT = 9;

   // Command codes {chip select, row strobe, column strobe, write command}, all active low
   localparam logic [3:0] CMD_MODE  = 4'h0;
   localparam logic [3:0] CMD_REF   = 4'h1;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ  = 4'h5;

   // Bank select value that picks the extended mode register
   localparam logic [1:0] EXT_MODE_BANK = 2'h1;

   // Burst and latency, counted in clock crossings (two per clock period)
   localparam logic [2:0] BURST_BEATS = 3'h4;
   localparam logic [2:0] RD_LAT_XING = 3'h2;

   // Reset values
   localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;

   typedef enum logic [1:0] {
      PWR_ON,
      PWR_PRE_PD,
      PWR_ACT_PD,
      PWR_SELF_REF
   } dpc_pwr_t;

   // Column address carried by the address pins of a read or write
   function automatic logic [COL_W-1:0] dpc_col_f(input logic [ADDR_W-1:0] addr);
      dpc_col_f = {addr[COL_HI_BIT], addr[7:0]};
   endfunction

   // Column of a given beat within a burst
   function automatic logic [COL_W-1:0] dpc_beat_col_f(input logic [COL_W-1:0] col, input logic [2:0] beat);
      dpc_beat_col_f = col + {6'h00, beat};
   endfunction

endpackage

//--- testbench.sv
// Self-checking bench for the DRAM pin command interface
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dpc_pkg::*;
   logic        clk_i = 1'b0, reset_i = 1'b1, rd_valid_i = 1'b0;
   logic [31:0] rd_data_i = 32'h0, rq[$];
   logic [44:0] wq[$];
   logic [3:0]  strobe_seen = 4'h0;
   int          bad_count = 0, n_compared = 0, cycles = 0;
   wire [31:0]  data_lines_o, wr_data_o, m_dq;
   wire [11:0]  acc_row_o, mode_reg_o, ext_mode_reg_o, addr_bus_i;
   wire [8:0]   acc_col_o;
   wire [3:0]   read_strobe_out_o, wr_byte_en_o, precharge_banks_o, bank_open_o, write_byte_mask_i, write_strobe_in_i;
   wire [1:0]   acc_bank_o, power_state_o, bank_select_i;
   wire         data_lines_oe_o, read_strobe_oe_o, rd_ready_o, act_o, rd_req_o, wr_valid_o, auto_precharge_o;
   wire         precharge_o, refresh_o, read_underrun_o, diff_clock_in_i, diff_clock_in_n_i, clk_enable_i;
   wire         chip_sel_n_i, row_strobe_n_i, col_strobe_n_i, write_cmd_n_i;
   wire [31:0]  data_lines_i = data_lines_oe_o ? data_lines_o : m_dq;
   dpc_dram_pins u_dpc_dram_pins (.*);
   dpc_ctrl_model u_dpc_ctrl_model (.clk_i(clk_i), .ck_o(diff_clock_in_i), .ck_n_o(diff_clock_in_n_i),
      .cke_o(clk_enable_i), .code_o({chip_sel_n_i, row_strobe_n_i, col_strobe_n_i, write_cmd_n_i}),
      .bank_o(bank_select_i), .addr_o(addr_bus_i), .mask_o(write_byte_mask_i), .wstrobe_o(write_strobe_in_i),
      .dq_o(m_dq));
   initial
   begin
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      strobe_seen <= read_strobe_out_o;
      if (data_lines_oe_o && read_strobe_out_o !== strobe_seen)
         rq.push_back(data_lines_o);
      if (wr_valid_o)
         wq.push_back({acc_col_o, wr_byte_en_o, wr_data_o});
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [44:0] got, input logic [44:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic t_mode();
      u_dpc_ctrl_model.cmd(CMD_MODE, 2'h0, 12'h5A3, 1'b1);
      chk(mode_reg_o, 12'h5A3, "mode register");
      u_dpc_ctrl_model.cmd(CMD_MODE, EXT_MODE_BANK, 12'h2C4, 1'b1);
      chk(ext_mode_reg_o, 12'h2C4, "extended mode");
      chk(mode_reg_o, 12'h5A3, "mode kept");
      $display("mode test done");
   endtask
   task automatic t_act();
      u_dpc_ctrl_model.cmd(CMD_ACT, 2'h2, 12'hABC, 1'b1);
      chk({acc_bank_o, acc_row_o}, {2'h2, 12'hABC}, "activate row");
      chk(bank_open_o, 4'h4, "open bank");
      u_dpc_ctrl_model.cmd(4'h8 | CMD_ACT, 2'h1, 12'h111, 1'b1);
      chk(bank_open_o, 4'h4, "deselected activate");
      $display("activate test done");
   endtask
   task automatic t_write();
      wq.delete();
      u_dpc_ctrl_model.cmd(CMD_WRITE, 2'h2, 12'h3FC, 1'b1);
      chk({acc_bank_o, auto_precharge_o}, {2'h2, 1'b1}, "write bank and auto precharge");
      u_dpc_ctrl_model.write_burst(32'hC0DE0010, 16'h0A51);
      repeat (8) @(negedge clk_i);
      chk(45'(wq.size()), 45'h4, "write beat count");
      for (int n = 0; n < 4; n++)
         chk(wq[n], {9'h1FC + 9'(n), ~(4'(16'h0A51 >> (4 * n))), 32'hC0DE0010 + 32'(n)}, "write beat");
      $display("write test done");
   endtask
   task automatic t_read();
      int k;
      k = 0;
      u_dpc_ctrl_model.cmd(CMD_ACT, 2'h1, 12'h040, 1'b1);
      while (rd_ready_o === 1'b1 && k < 20)
      begin
         rd_data_i  = 32'hA5000000 + 32'(k);
         rd_valid_i = 1'b1;
         @(negedge clk_i);
         k++;
      end
      rd_valid_i = 1'b0;
      chk(45'(k), 45'(FIFO_DEPTH), "buffer fill count");
      rq.delete();
      for (int b = 0; b < 4; b++)
      begin
         u_dpc_ctrl_model.cmd(CMD_READ, 2'h1, 12'h204 + 12'(b * 4), 1'b1);
         chk({auto_precharge_o, acc_col_o}, {1'b0, 9'h104 + 9'(b * 4)}, "read column");
         repeat (32) @(negedge clk_i);
      end
      for (int n = 0; n < 16; n++)
         chk(rq[n], 32'hA5000000 + 32'(n), "read beat");
      $display("read test done");
   endtask
   task automatic t_pre();
      u_dpc_ctrl_model.cmd(CMD_ACT, 2'h0, 12'h001, 1'b1);
      u_dpc_ctrl_model.cmd(CMD_PRE, 2'h0, 12'h000, 1'b1);
      chk({precharge_banks_o, bank_open_o[0]}, {4'h1, 1'b0}, "single precharge");
      u_dpc_ctrl_model.cmd(CMD_PRE, 2'h0, 12'h100, 1'b1);
      chk({precharge_banks_o, bank_open_o}, {4'hF, 4'h0}, "precharge all");
      u_dpc_ctrl_model.cmd(CMD_REF, 2'h0, 12'h000, 1'b1);
      chk({power_state_o, bank_open_o}, {PWR_ON, 4'h0}, "auto refresh");
      $display("precharge test done");
   endtask
   task automatic t_power();
      u_dpc_ctrl_model.cmd(CMD_ACT, 2'h3, 12'h777, 1'b1);
      u_dpc_ctrl_model.cmd(4'hF, 2'h0, 12'h000, 1'b0);
      chk(power_state_o, PWR_ACT_PD, "active power-down");
      u_dpc_ctrl_model.cmd(CMD_ACT, 2'h0, 12'h001, 1'b0);
      chk(bank_open_o, 4'h8, "command while down");
      u_dpc_ctrl_model.cmd(4'hF, 2'h0, 12'h000, 1'b1);
      chk(power_state_o, PWR_ON, "power-down exit");
      u_dpc_ctrl_model.cmd(CMD_PRE, 2'h0, 12'h100, 1'b1);
      u_dpc_ctrl_model.cmd(4'hF, 2'h0, 12'h000, 1'b0);
      chk(power_state_o, PWR_PRE_PD, "precharge power-down");
      u_dpc_ctrl_model.cmd(4'hF, 2'h0, 12'h000, 1'b1);
      u_dpc_ctrl_model.cmd(CMD_REF, 2'h0, 12'h000, 1'b0);
      chk(power_state_o, PWR_SELF_REF, "self refresh");
      u_dpc_ctrl_model.sr_exit();
      chk(power_state_o, PWR_ON, "self refresh exit without clock");
      u_dpc_ctrl_model.restart();
      $display("power test done");
   endtask
   initial
   begin
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      repeat (8) @(negedge clk_i);
      t_mode();
      t_act();
      t_write();
      t_read();
      t_pre();
      t_power();
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
